// ### spc_defines.svh
/*
 * Shared constants for the pipelined synchronous SRAM pin-control block:
 * array geometry, pin active levels, strap defaults and reset values.
 * Assumes it is included by bare name from every file that needs it.
 */
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

// array geometry
`define SPC_ADDR_W          18
`define SPC_DATA_W          16
`define SPC_PAR_W           2
`define SPC_LANE_W          8
`define SPC_BURST_W         2

// active levels of the select and control pins
`define SPC_CS_A_ON         1'b0
`define SPC_CS_B_ON         1'b1
`define SPC_CS_C_ON         1'b0
`define SPC_QUALIFY_ON      1'b0
`define SPC_WRITE_ON        1'b0
`define SPC_LOAD_LEVEL      1'b0
`define SPC_LANE_ON         1'b0
`define SPC_OE_ON           1'b0

// burst-order strap levels
`define SPC_ORDER_INTERLEAVED 1'b1
`define SPC_STRAP_FLOAT_LEVEL 1'b1

// reset values and the burst count step
`define SPC_RST_DRIVE       1'b0
`define SPC_RST_LANES       2'h3
`define SPC_BURST_FIRST     2'h0
`define SPC_BURST_STEP      2'h1

`endif

// ### spc_pkg.sv
/*
 * Types shared by the SRAM pin-control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package spc_pkg;

   // access type carried through the pipeline stages
   typedef enum logic [1:0] {
      SPC_OP_IDLE,
      SPC_OP_READ,
      SPC_OP_WRITE
   } spc_op_e;

endpackage

// ### spc_burst_order.sv
/*
 * Burst address order: maps a burst step count onto the low address bits,
 * linear (add) or interleaved (exclusive or).
 * Assumes the caller holds base and count stable around the clock edge.
 */
`timescale 1ns/1ps

module spc_burst_order #(
   parameter int BURST_W = 2
) (
   // burst inputs
   input  wire logic [BURST_W-1:0] base,
   input  wire logic [BURST_W-1:0] count,
   input  wire logic               interleaved,
   // low address bits of this beat
   output logic      [BURST_W-1:0] offset
);

   // both orders wrap naturally at the burst width
   always_comb begin
      if (interleaved) begin
         offset = base ^ count;
      end else begin
         offset = BURST_W'(base + count);
      end
   end

endmodule

// ### spc_sram_ctrl.sv
/*
 * Device-side logic of a pipelined synchronous burst SRAM: chip-select
 * decode, clock qualify, read/write pipeline, byte-lane writes, burst
 * order and the direction control of the data and parity pins.
 * Assumes all synchronous inputs are synchronous to clk and that the
 * shared wire level is resolved outside from the output enables.
 */
`timescale 1ns/1ps
`include "spc_defines.svh"

module spc_sram_ctrl #(
   parameter int ADDR_W  = `SPC_ADDR_W,
   parameter int DATA_W  = `SPC_DATA_W,
   parameter int PAR_W   = `SPC_PAR_W,
   parameter int LANE_W  = `SPC_LANE_W,
   parameter int BURST_W = `SPC_BURST_W
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              arst_n,
   // selects and clock qualify
   input  wire logic              chip_select_a_n,
   input  wire logic              chip_select_b,
   input  wire logic              chip_select_c_n,
   input  wire logic              clock_qualify_n,
   // access control
   input  wire logic              write_enable_n,
   input  wire logic              advance_load,
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic [PAR_W-1:0]  byte_lane_write_select_n,
   input  wire logic              output_drive_enable_n,
   // burst-order strap
   input  wire logic              burst_order_strap,
   input  wire logic              burst_strap_connected,
   // data lines
   input  wire logic [DATA_W-1:0] data_lines_in,
   output logic      [DATA_W-1:0] data_lines_out,
   output logic      [DATA_W-1:0] data_lines_oe,
   // parity lines
   input  wire logic [PAR_W-1:0]  parity_lines_in,
   output logic      [PAR_W-1:0]  parity_lines_out,
   output logic      [PAR_W-1:0]  parity_lines_oe
);

   // stored word width and the address bits above the burst counter
   localparam int WORD_W = DATA_W + PAR_W;
   localparam int HIGH_W = ADDR_W - BURST_W;

   // reset release
   logic                 rst_meta_n;
   logic                 rst_n;

   // burst state
   spc_pkg::spc_op_e     burst_op;
   logic [HIGH_W-1:0]    burst_high;
   logic [BURST_W-1:0]   burst_base;
   logic [BURST_W-1:0]   burst_count;
   logic                 order_interleaved;
   spc_pkg::spc_op_e     next_burst_op;
   logic [HIGH_W-1:0]    next_burst_high;
   logic [BURST_W-1:0]   next_burst_base;
   logic [BURST_W-1:0]   next_burst_count;
   logic                 next_order_interleaved;
   logic [BURST_W-1:0]   step_count;
   logic [BURST_W-1:0]   step_offset;

   // address stage
   spc_pkg::spc_op_e     s1_op;
   logic [ADDR_W-1:0]    s1_addr;
   logic [PAR_W-1:0]     s1_lanes_n;
   spc_pkg::spc_op_e     next_s1_op;
   logic [ADDR_W-1:0]    next_s1_addr;
   logic [PAR_W-1:0]     next_s1_lanes_n;

   // write data stage
   spc_pkg::spc_op_e     s2_op;
   logic [ADDR_W-1:0]    s2_addr;
   logic [PAR_W-1:0]     s2_lanes_n;
   spc_pkg::spc_op_e     next_s2_op;
   logic [ADDR_W-1:0]    next_s2_addr;
   logic [PAR_W-1:0]     next_s2_lanes_n;

   // output register and drive window
   logic [WORD_W-1:0]    out_word;
   logic                 drive_window;
   logic [WORD_W-1:0]    next_out_word;
   logic                 next_drive_window;

   // storage array and its write port
   // sized by the full address width; a bench keeps ADDR_W small to stay light
   logic [WORD_W-1:0]    mem [0:(1<<ADDR_W)-1];
   logic                 mem_we;
   logic [WORD_W-1:0]    mem_wdata;
   logic [WORD_W-1:0]    lane_mask;
   logic [WORD_W-1:0]    in_word;
   logic                 selected;
   logic                 pin_drive;

   // the reset is released through two flops; the array itself has no reset
   // the released copy reaches every pipeline flop on the same edge, so no
   // stage can start before the one ahead of it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_n <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n      <= rst_meta_n;
      end
   end

   // combined select decode
   // any one select off turns a load beat into a deselect
   assign selected = (chip_select_a_n == `SPC_CS_A_ON) &&
                     (chip_select_b   == `SPC_CS_B_ON) &&
                     (chip_select_c_n == `SPC_CS_C_ON);

   // parity bits ride on top of the data bits as one stored word
   assign in_word = {parity_lines_in, data_lines_in};

   // per-bit write mask built from the lanes of the write in flight
   // these are the lanes of the committing write, not those on the pins now
   always_comb begin
      lane_mask = '0;
      for (int i = 0; i < DATA_W; i++) begin
         lane_mask[i] = (s2_lanes_n[i / LANE_W] == `SPC_LANE_ON);
      end
      for (int p = 0; p < PAR_W; p++) begin
         lane_mask[DATA_W + p] = (s2_lanes_n[p] == `SPC_LANE_ON);
      end
   end

   // next beat of a burst continues from the loaded base
   // the count simply wraps, so a long burst revisits the same words
   assign step_count = BURST_W'(burst_count + `SPC_BURST_STEP);

   spc_burst_order #(
      .BURST_W (BURST_W)
   ) u_burst_order (
      .base        (burst_base),
      .count       (step_count),
      .interleaved (order_interleaved),
      .offset      (step_offset)
   );

   // burst and address stage; an unqualified edge leaves every value as is
   // lane selects are taken on every beat, so a burst may change lanes per word;
   // selects and write enable only count on a load beat
   always_comb begin
      next_burst_op          = burst_op;
      next_burst_high        = burst_high;
      next_burst_base        = burst_base;
      next_burst_count       = burst_count;
      next_order_interleaved = order_interleaved;
      next_s1_op             = s1_op;
      next_s1_addr           = s1_addr;
      next_s1_lanes_n        = s1_lanes_n;
      if (clock_qualify_n == `SPC_QUALIFY_ON) begin
         // the strap is only ever sampled, never assumed to move
         if (burst_strap_connected) begin
            next_order_interleaved =
               (burst_order_strap == `SPC_ORDER_INTERLEAVED);
         end else begin
            next_order_interleaved =
               (`SPC_STRAP_FLOAT_LEVEL == `SPC_ORDER_INTERLEAVED);
         end
         next_s1_lanes_n = byte_lane_write_select_n;
         if (advance_load == `SPC_LOAD_LEVEL) begin
            // load: the select decides whether any access starts
            if (selected) begin
               next_burst_op = (write_enable_n == `SPC_WRITE_ON) ?
                               spc_pkg::SPC_OP_WRITE : spc_pkg::SPC_OP_READ;
            end else begin
               next_burst_op = spc_pkg::SPC_OP_IDLE;
            end
            next_burst_high  = address[ADDR_W-1:BURST_W];
            next_burst_base  = address[BURST_W-1:0];
            next_burst_count = `SPC_BURST_FIRST;
            next_s1_op       = next_burst_op;
            next_s1_addr     = address;
         end else begin
            // advance: selects and write enable are not looked at
            next_burst_count = step_count;
            next_s1_op       = burst_op;
            next_s1_addr     = {burst_high, step_offset};
         end
      end
   end

   // burst and address-stage registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         burst_op          <= spc_pkg::SPC_OP_IDLE;
         burst_high        <= '0;
         burst_base        <= '0;
         burst_count       <= `SPC_BURST_FIRST;
         order_interleaved <= `SPC_STRAP_FLOAT_LEVEL;
         s1_op             <= spc_pkg::SPC_OP_IDLE;
         s1_addr           <= '0;
         s1_lanes_n        <= `SPC_RST_LANES;
      end else begin
         burst_op          <= next_burst_op;
         burst_high        <= next_burst_high;
         burst_base        <= next_burst_base;
         burst_count       <= next_burst_count;
         order_interleaved <= next_order_interleaved;
         s1_op             <= next_s1_op;
         s1_addr           <= next_s1_addr;
         s1_lanes_n        <= next_s1_lanes_n;
      end
   end

   // write data stage, output register and drive window
   // the commit waits one edge past the data phase opening, which gives the far
   // side a whole cycle to turn the shared pins around before they are sampled
   always_comb begin
      next_s2_op        = s2_op;
      next_s2_addr      = s2_addr;
      next_s2_lanes_n   = s2_lanes_n;
      next_out_word     = out_word;
      next_drive_window = drive_window;
      mem_we            = 1'b0;
      mem_wdata         = (mem[s2_addr] & ~lane_mask) | (in_word & lane_mask);
      if (clock_qualify_n == `SPC_QUALIFY_ON) begin
         // a write commits the pin data one edge after its data phase opens
         mem_we          = (s2_op == spc_pkg::SPC_OP_WRITE);
         next_s2_op      = (s1_op == spc_pkg::SPC_OP_WRITE) ?
                           spc_pkg::SPC_OP_WRITE : spc_pkg::SPC_OP_IDLE;
         next_s2_addr    = s1_addr;
         next_s2_lanes_n = s1_lanes_n;
         case (s1_op)
            spc_pkg::SPC_OP_READ: begin
               // forward a write landing on the same word at this edge
               if (mem_we && (s2_addr == s1_addr)) begin
                  next_out_word = mem_wdata;
               end else begin
                  next_out_word = mem[s1_addr];
               end
               next_drive_window = 1'b1;
            end
            spc_pkg::SPC_OP_WRITE: begin
               next_drive_window = 1'b0;
            end
            spc_pkg::SPC_OP_IDLE: begin
               next_drive_window = 1'b0;
            end
            default: begin
               next_drive_window = 1'b0;
            end
         endcase
      end
   end

   // write-stage and output registers; the pins read the output word off a flop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s2_op        <= spc_pkg::SPC_OP_IDLE;
         s2_addr      <= '0;
         s2_lanes_n   <= `SPC_RST_LANES;
         out_word     <= '0;
         drive_window <= `SPC_RST_DRIVE;
      end else begin
         s2_op        <= next_s2_op;
         s2_addr      <= next_s2_addr;
         s2_lanes_n   <= next_s2_lanes_n;
         out_word     <= next_out_word;
         drive_window <= next_drive_window;
      end
   end

   // array write port; unselected lanes keep their old contents
   // the array has no reset, so a word read before any write returns unknowns
   always_ff @(posedge clk) begin
      if (mem_we) begin
         mem[s2_addr] <= mem_wdata;
      end
   end

   // the enable pin gates the window without a clock, so turn-around is
   // as fast as the pin; the window itself only opens after a read edge
   assign pin_drive = drive_window &&
                      (output_drive_enable_n == `SPC_OE_ON);

   // pin outputs
   // every data and parity bit shares one enable, so all turn around together
   assign data_lines_out   = out_word[DATA_W-1:0];
   assign parity_lines_out = out_word[WORD_W-1:DATA_W];
   assign data_lines_oe    = {DATA_W{pin_drive}};
   assign parity_lines_oe  = {PAR_W{pin_drive}};

endmodule

// ### spc_properties.sv
/*
 * Pin-level checker for the pipelined SRAM pin-control block, bound to its top.
 * Assumes one clock domain and the top module's port names.
 */
`timescale 1ns/1ps

module spc_properties #(
   parameter int DATA_W = 16,
   parameter int PAR_W  = 2
) (
   // clock and reset
   input wire logic              clk,
   input wire logic              arst_n,
   // selects and controls
   input wire logic              chip_select_a_n,
   input wire logic              chip_select_b,
   input wire logic              chip_select_c_n,
   input wire logic              clock_qualify_n,
   input wire logic              write_enable_n,
   input wire logic              advance_load,
   input wire logic              output_drive_enable_n,
   // pin outputs
   input wire logic [DATA_W-1:0] data_lines_out,
   input wire logic [DATA_W-1:0] data_lines_oe,
   input wire logic [PAR_W-1:0]  parity_lines_oe
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   // qualified load beat and select decode
   logic sel;
   logic ld;
   assign sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
   assign ld  = !clock_qualify_n && !advance_load;

   enable_off_a: assert property (output_drive_enable_n |-> data_lines_oe == '0)
      else $error("data pins driven while output enable is high");
   lanes_equal_a: assert property (parity_lines_oe == {PAR_W{data_lines_oe[0]}}
      && (data_lines_oe == '0 || data_lines_oe == '1))
      else $error("parity and data enables disagree");
   read_drive_a: assert property (ld && sel && write_enable_n ##1 !clock_qualify_n
      |=> output_drive_enable_n || data_lines_oe == '1)
      else $error("read answer not driven");
   write_mask_a: assert property (ld && sel && !write_enable_n ##1 !clock_qualify_n
      |=> data_lines_oe == '0)
      else $error("pins driven in write data phase");
   deselect_release_a: assert property (ld && !sel ##1 !clock_qualify_n
      |=> data_lines_oe == '0)
      else $error("pins driven after deselect");
   freeze_hold_a: assert property (clock_qualify_n |=> $stable(data_lines_out))
      else $error("output word moved on an ignored edge");
   freeze_window_a: assert property (clock_qualify_n ##1 $stable(output_drive_enable_n)
      |-> $stable(data_lines_oe))
      else $error("drive window moved on an ignored edge");
   stretch_write_a: assert property (ld && sel && !write_enable_n
      ##1 clock_qualify_n ##1 !clock_qualify_n |=> data_lines_oe == '0)
      else $error("stretched write data phase driven");
endmodule

bind spc_sram_ctrl spc_properties #(.DATA_W(DATA_W), .PAR_W(PAR_W)) u_spc_properties (.*);

// ### spc_bus_master.sv
/*
 * Far-side bus master model: resolves the shared data and parity wire.
 * Assumes the testbench tells it when to drive write data.
 */
`timescale 1ns/1ps

module spc_bus_master #(
   parameter int W = 18
) (
   // clock
   input  wire logic         clk,
   // master write data
   input  wire logic         drive,
   input  wire logic [W-1:0] wdata,
   // device side of the pins
   input  wire logic [W-1:0] dev_oe,
   input  wire logic [W-1:0] dev_out,
   // resolved wire level
   output logic      [W-1:0] level
);
   logic [W-1:0] held = '0;

   // released bits toggle each cycle so stale data never passes as valid
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (dev_oe[i] && drive) level[i] = 1'bx; // contention shows up as unknown
         else if (dev_oe[i]) level[i] = dev_out[i];
         else if (drive) level[i] = wdata[i];
         else level[i] = ~held[i];
      end
   end

   // last wire level, for the floating pattern
   always_ff @(posedge clk) held <= level;
endmodule

// ### testbench.sv
/*
 * Self-checking bench for the SRAM pin-control block.
 * Assumes the checker binds itself and the bus master resolves the wire.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end

module testbench;
   localparam int AW = 4;
   localparam logic [2:0] SEL = 3'h2;
   localparam logic [2:0] DES = 3'h7;
   localparam logic [1:0] RD = 2'h0;
   localparam logic [1:0] WR = 2'h1;
   localparam logic [1:0] ADV = 2'h2;
   localparam logic [1:0] NL = 2'h3;
   logic clk = 1'h0, arst_n = 1'h0, q_n = 1'h0, we_n = 1'h1, adv = 1'h0, oe_n = 1'h0;
   logic strap = 1'h1, conn = 1'h1, drive = 1'h0;
   logic [2:0] cs = DES;
   logic [1:0] lanes = NL;
   logic [AW-1:0] addr = '0;
   logic [17:0] wd = '0;
   logic [15:0] dout, doe;
   logic [1:0] pout, poe, lt;
   logic [17:0] lvl;
   logic [17:0] mem [16];
   logic [24:0] p0, p1; // write pipe: valid, lanes, address, data
   logic chk_on = 1'h0, av, rv;
   logic [AW-1:0] aa, ra;
   int fails = 0;
   int comparisons = 0;

   spc_sram_ctrl #(.ADDR_W(AW)) u_spc_sram_ctrl (
      .clk(clk), .arst_n(arst_n), .chip_select_a_n(cs[2]), .chip_select_b(cs[1]),
      .chip_select_c_n(cs[0]), .clock_qualify_n(q_n), .write_enable_n(we_n),
      .advance_load(adv), .address(addr), .byte_lane_write_select_n(lanes),
      .output_drive_enable_n(oe_n), .burst_order_strap(strap), .burst_strap_connected(conn),
      .data_lines_in(lvl[15:0]), .data_lines_out(dout), .data_lines_oe(doe),
      .parity_lines_in(lvl[17:16]), .parity_lines_out(pout), .parity_lines_oe(poe));
   spc_bus_master u_spc_bus_master (.clk(clk), .drive(drive), .wdata(wd),
      .dev_oe({poe, doe}), .dev_out({pout, dout}), .level(lvl));

   always #2 clk = ~clk;

   task automatic test_done;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one beat: checks the cycle's answer, then tracks read and write pipes per counted edge
   task automatic op(input logic [2:0] c, input logic [1:0] k, input logic [AW-1:0] ad,
                     input logic [17:0] d, input logic [1:0] l);
      {cs, we_n, adv, addr, lanes} = {c, !k[0], k[1], ad, l};
      {drive, wd} = {p1[24], p1[17:0]};
      #0.5;
      if (chk_on && av && !oe_n) `CHK("read word", mem[aa], lvl)
      else if (chk_on) `CHK("drive enable", 18'h0, {poe, doe})
      @(posedge clk);
      #1;
      if (!q_n) begin
         if (p1[24] && !p1[22]) {mem[p1[21:18]][16], mem[p1[21:18]][7:0]} = {p1[16], p1[7:0]};
         if (p1[24] && !p1[23]) {mem[p1[21:18]][17], mem[p1[21:18]][15:8]} = {p1[17], p1[15:8]};
         if (!k[1]) lt = (c != SEL) ? 2'h0 : (k[0] ? 2'h2 : 2'h1);
         p1 = p0;
         p0 = {lt == 2'h2, l, ad, d};
         {av, aa, rv, ra} = {rv, ra, lt == 2'h1, ad};
      end
   endtask

   task automatic idle(input int n);
      repeat (n) op(DES, RD, 4'h0, 18'h0, NL);
   endtask

   // strap only moves while the part is held in reset
   task automatic rst(input logic s, input logic cn);
      {arst_n, chk_on, strap, conn, drive} = {1'h0, 1'h0, s, cn, 1'h0};
      {p0, p1, av, rv, lt} = '0;
      repeat (6) @(posedge clk);
      #1;
      arst_n = 1'h1;
      idle(2);
      chk_on = 1'h1;
   endtask

   task automatic t_rw;
      for (int i = 0; i < 4; i++) op(SEL, WR, 4'(i), 18'h2a5c0 + 18'(i), 2'h0);
      op(SEL, WR, 4'h1, 18'h15a3f, 2'h2);
      op(SEL, RD, 4'h1, 18'h0, NL);
      op(SEL, WR, 4'h2, 18'h3c3c3, 2'h1);
      for (int i = 0; i < 4; i++) op(SEL, RD, 4'(i), 18'h0, NL);
      idle(2);
      $display("t_rw finished");
   endtask

   task automatic t_oe;
      op(SEL, RD, 4'h0, 18'h0, NL);
      op(SEL, RD, 4'h1, 18'h0, NL);
      oe_n = 1'h1;
      op(SEL, RD, 4'h3, 18'h0, NL);
      oe_n = 1'h0;
      idle(3); // enable falls mid-answer
      $display("t_oe finished");
   endtask

   task automatic t_sel;
      for (int i = 0; i < 8; i++) op(3'(i), RD, 4'h2, 18'h0, NL);
      idle(2);
      $display("t_sel finished");
   endtask

   task automatic t_freeze;
      op(SEL, RD, 4'h1, 18'h0, NL);
      q_n = 1'h1;
      op(DES, RD, 4'h5, 18'h0, NL); // read answer must not open here
      q_n = 1'h0;
      op(SEL, WR, 4'h9, 18'h0f0f0, 2'h0);
      q_n = 1'h1;
      op(DES, RD, 4'h5, 18'h0, NL); // ignored edge with selects off
      q_n = 1'h0;
      op(SEL, RD, 4'h9, 18'h0, NL); // stretched answer still checked here
      idle(2);
      $display("t_freeze finished");
   endtask

   task automatic t_burst(input logic s, input logic cn);
      logic il;
      rst(s, cn);
      il = cn ? s : 1'h1; // a floating strap reads as interleaved
      for (int i = 0; i < 4; i++) op(SEL, WR, 4'h4 + 4'(i), 18'h1d2c0 + 18'(i), 2'h0);
      op(SEL, RD, 4'h5, 18'h0, NL);
      for (int k = 1; k < 4; k++) op(DES, ADV, {2'h1, il ? 2'h1 ^ 2'(k) : 2'h1 + 2'(k)}, 18'h0, NL);
      idle(2);
      $display("t_burst finished");
   endtask

   initial begin
      rst(1'h1, 1'h1);
      t_rw;
      t_oe;
      t_sel;
      t_freeze;
      t_burst(1'h1, 1'h1);
      t_burst(1'h0, 1'h1);
      t_burst(1'h0, 1'h0);
      test_done;
   end

   // watchdog, far beyond the hundred or so cycles the tests need
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      test_done;
   end
endmodule
